// [shared/afr_pkg.sv]
/*
 * Constants of the ADC and timed fault response block: command codes, field
 * layouts, status bit positions, reset values and the channel state type.
 * Assumes the host command decoder delivers decoded byte reads and writes.
 */
package afr_pkg;

   localparam int NUM_CHAN = 8;

   // ------------------------------------------------------------------
   // command codes
   // ------------------------------------------------------------------
   localparam logic [7:0] CMD_CLEAR_FAULTS   = 8'h03;
   localparam logic [7:0] CMD_STATUS_BYTE    = 8'h78;
   localparam logic [7:0] CMD_STATUS_WORD_HI = 8'h7A;
   localparam logic [7:0] CMD_STATUS_INPUT   = 8'h7C;
   localparam logic [7:0] CMD_STATUS_TEMP    = 8'h7D;
   localparam logic [7:0] CMD_TON_FLAGS      = 8'hD8;
   localparam logic [7:0] CMD_OT_REACT       = 8'h50;
   localparam logic [7:0] CMD_UT_REACT       = 8'h54;
   localparam logic [7:0] CMD_VIN_OV_REACT   = 8'h56;
   localparam logic [7:0] CMD_VIN_UV_REACT   = 8'h5A;
   localparam logic [7:0] CMD_TON_REACT      = 8'h63;
   localparam logic [7:0] CMD_RESTART_LIMIT  = 8'hD7;

   // ------------------------------------------------------------------
   // reaction register layout
   // ------------------------------------------------------------------
   localparam int ACT_MSB   = 7;
   localparam int ACT_LSB   = 6;
   localparam int RETRY_MSB = 5;
   localparam int RETRY_LSB = 3;
   localparam logic [2:0] DELAY_HARD = 3'h0;
   localparam logic [7:0] REACT_RST  = 8'h00;
   localparam logic [2:0] LIMIT_RST  = 3'h0;

   // ------------------------------------------------------------------
   // status bit positions
   // ------------------------------------------------------------------
   localparam int SB_HIGH_BYTE = 0;
   localparam int SB_TEMP      = 2;
   localparam int SB_VIN_UV    = 3;
   localparam int SW_INPUT     = 5;   // bit 13 of the word, bit 5 of its high byte
   localparam int SW_VOUT      = 7;   // bit 15 of the word
   localparam int SI_VIN_OV    = 7;
   localparam int SI_VIN_UV    = 4;
   localparam int ST_OT        = 7;
   localparam int ST_UT        = 4;

   typedef enum logic [2:0] {
      CH_OFF, CH_RUN, CH_SEQ_OFF, CH_RESTART, CH_LATCHED
   } afr_chan_e;

   // shutdown is any nonzero action code
   function automatic logic afr_shuts(input logic [7:0] react);
      return react[ACT_MSB:ACT_LSB] != 2'h0;
   endfunction

   function automatic logic [2:0] afr_retry(input logic [7:0] react);
      return react[RETRY_MSB:RETRY_LSB];
   endfunction

endpackage

// [shared/afr_chan_if.sv]
/*
 * Carrier between the fault response core and one channel controller.
 * Assumes one instance per channel, all on the block clock.
 */
`timescale 1ns/1ps
interface afr_chan_if;
   logic       fault_shut;
   logic [2:0] retry_field;
   logic       seq_style;
   logic       toff_done;
   logic       on_cmd;
   logic       release_latch;
   logic       bias_ok;
   logic [2:0] retry_limit;
   logic       chan_en;
   logic       latched;

   modport core (output fault_shut, retry_field, seq_style, toff_done, on_cmd,
                 release_latch, bias_ok, retry_limit,
                 input chan_en, latched);
   modport chan (input fault_shut, retry_field, seq_style, toff_done, on_cmd,
                 release_latch, bias_ok, retry_limit,
                 output chan_en, latched);
endinterface

// [hw/afr_chan_ctl.sv]
/*
 * One channel's shutdown, retry and latch state machine.
 * Assumes the turn-off sequencer returns a done pulse after the off delay.
 */
`timescale 1ns/1ps
module afr_chan_ctl (
   input  wire logic mclk,
   input  wire logic srst,
   afr_chan_if.chan  cif
);
   afr_pkg::afr_chan_e state_r, state_nxt;
   logic [2:0]         retry_r, retry_nxt;
   logic [2:0]         cnt_r, cnt_nxt;
   logic               stop_r, stop_nxt;
   logic               en_r, lat_r;

   // retry field and stop condition as seen at the moment of deciding
   wire logic [2:0] dec_retry = (state_r == afr_pkg::CH_RUN) ? cif.retry_field : retry_r;
   wire logic       dec_stop  = (state_r == afr_pkg::CH_SEQ_OFF) && (stop_r || cif.fault_shut);
   wire logic       give_up   = (dec_retry == 3'h0) || dec_stop
                                || (cnt_r == cif.retry_limit);
   wire afr_pkg::afr_chan_e decide = give_up ? afr_pkg::CH_LATCHED : afr_pkg::CH_RESTART;

   always_comb begin
      state_nxt = state_r;
      retry_nxt = retry_r;
      cnt_nxt   = cnt_r;
      stop_nxt  = stop_r;
      if (!cif.bias_ok) begin
         // bias loss ends everything, including a latched fault
         state_nxt = afr_pkg::CH_OFF;
         cnt_nxt   = 3'h0;
      end else begin
         unique case (state_r)
            afr_pkg::CH_OFF: begin
               if (cif.on_cmd) state_nxt = afr_pkg::CH_RUN;
            end
            afr_pkg::CH_RUN: begin
               if (cif.fault_shut) begin
                  retry_nxt = cif.retry_field;
                  stop_nxt  = 1'b0;
                  state_nxt = cif.seq_style ? afr_pkg::CH_SEQ_OFF : decide;
               end else if (!cif.on_cmd) begin
                  state_nxt = afr_pkg::CH_OFF;
                  cnt_nxt   = 3'h0;
               end
            end
            afr_pkg::CH_SEQ_OFF: begin
               if (cif.fault_shut) stop_nxt = 1'b1;
               if (cif.toff_done) state_nxt = decide;
            end
            afr_pkg::CH_RESTART: begin
               cnt_nxt = cnt_r + 3'h1;
               // another fault or an off command ends the retry run
               if (cif.fault_shut) state_nxt = afr_pkg::CH_LATCHED;
               else if (cif.on_cmd) state_nxt = afr_pkg::CH_RUN;
               else state_nxt = afr_pkg::CH_OFF;
            end
            afr_pkg::CH_LATCHED: begin
               if (cif.release_latch) begin
                  state_nxt = afr_pkg::CH_OFF;
                  cnt_nxt   = 3'h0;
               end
            end
            default: state_nxt = afr_pkg::CH_OFF;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         state_r <= afr_pkg::CH_OFF;
         retry_r <= 3'h0;
         cnt_r   <= 3'h0;
         stop_r  <= 1'b0;
         en_r    <= 1'b0;
         lat_r   <= 1'b0;
      end else begin
         state_r <= state_nxt;
         retry_r <= retry_nxt;
         cnt_r   <= cnt_nxt;
         stop_r  <= stop_nxt;
         en_r    <= (state_nxt == afr_pkg::CH_RUN) || (state_nxt == afr_pkg::CH_SEQ_OFF);
         lat_r   <= (state_nxt == afr_pkg::CH_LATCHED);
      end
   end

   assign cif.chan_en = en_r;
   assign cif.latched = lat_r;
endmodule

// [hw/afr_fault_resp.sv]
/*
 * ADC-measured and start-up timeout fault response: reaction registers,
 * status flags, host alert and eight channel controllers.
 * Assumes conversion strobes and limit compares come from the ADC monitor,
 * command writes and reads come decoded from the PMBus front end, and all
 * inputs are synchronous to mclk.
 */
`timescale 1ns/1ps
module afr_fault_resp (
   input  wire logic       mclk,
   input  wire logic       srst,
   input  wire logic       cmd_wr,
   input  wire logic       cmd_rd,
   input  wire logic [7:0] cmd_code,
   input  wire logic [7:0] cmd_wdata,
   input  wire logic       temp_conv_done,
   input  wire logic       temp_over_limit,
   input  wire logic       temp_under_limit,
   input  wire logic       vin_conv_done,
   input  wire logic       vin_over_limit,
   input  wire logic       vin_under_limit,
   input  wire logic [7:0] ton_max_expired,
   input  wire logic [7:0] channel_control_pin,
   input  wire logic [7:0] operation_on,
   input  wire logic [7:0] operation_wr,
   input  wire logic [7:0] on_off_config_wr,
   input  wire logic [7:0] shutdown_style,
   input  wire logic [7:0] toff_done,
   input  wire logic       bias_ok,
   output logic      [7:0] rd_data,
   output logic            rd_valid,
   output logic      [7:0] chan_enable,
   output logic      [7:0] chan_latched,
   output logic            host_alert_n
);

   // ------------------------------------------------------------------
   // reaction registers
   // ------------------------------------------------------------------
   logic [7:3] ot_react_r;
   logic [7:3] ut_react_r;
   logic [7:3] vin_ov_react_r;
   logic [7:3] vin_uv_react_r;
   logic [7:3] ton_react_r;
   logic [2:0] limit_r;

   // delay bits are not stored at all, so they can only read as zero
   wire logic [7:0] ot_react     = {ot_react_r,     afr_pkg::DELAY_HARD};
   wire logic [7:0] ut_react     = {ut_react_r,     afr_pkg::DELAY_HARD};
   wire logic [7:0] vin_ov_react = {vin_ov_react_r, afr_pkg::DELAY_HARD};
   wire logic [7:0] vin_uv_react = {vin_uv_react_r, afr_pkg::DELAY_HARD};
   wire logic [7:0] ton_react    = {ton_react_r,    afr_pkg::DELAY_HARD};

   wire logic wr_ot     = cmd_wr && (cmd_code == afr_pkg::CMD_OT_REACT);
   wire logic wr_ut     = cmd_wr && (cmd_code == afr_pkg::CMD_UT_REACT);
   wire logic wr_vin_ov = cmd_wr && (cmd_code == afr_pkg::CMD_VIN_OV_REACT);
   wire logic wr_vin_uv = cmd_wr && (cmd_code == afr_pkg::CMD_VIN_UV_REACT);
   wire logic wr_ton    = cmd_wr && (cmd_code == afr_pkg::CMD_TON_REACT);
   wire logic wr_limit  = cmd_wr && (cmd_code == afr_pkg::CMD_RESTART_LIMIT);
   wire logic clr_flt   = cmd_wr && (cmd_code == afr_pkg::CMD_CLEAR_FAULTS);

   always_ff @(posedge mclk) begin
      if (srst) begin
         ot_react_r     <= afr_pkg::REACT_RST[7:3];
         ut_react_r     <= afr_pkg::REACT_RST[7:3];
         vin_ov_react_r <= afr_pkg::REACT_RST[7:3];
         vin_uv_react_r <= afr_pkg::REACT_RST[7:3];
         ton_react_r    <= afr_pkg::REACT_RST[7:3];
         limit_r        <= afr_pkg::LIMIT_RST;
      end else begin
         if (wr_ot)     ot_react_r     <= cmd_wdata[7:3];
         if (wr_ut)     ut_react_r     <= cmd_wdata[7:3];
         if (wr_vin_ov) vin_ov_react_r <= cmd_wdata[7:3];
         if (wr_vin_uv) vin_uv_react_r <= cmd_wdata[7:3];
         if (wr_ton)    ton_react_r    <= cmd_wdata[7:3];
         if (wr_limit)  limit_r        <= cmd_wdata[2:0];
      end
   end

   // ------------------------------------------------------------------
   // fault detection
   // ------------------------------------------------------------------
   // limits are looked at only on the strobe of a finished conversion, so a
   // stale compare between results never raises a second event
   wire logic evt_ot     = temp_conv_done && temp_over_limit;
   wire logic evt_ut     = temp_conv_done && temp_under_limit;
   wire logic evt_vin_ov = vin_conv_done && vin_over_limit;
   wire logic evt_vin_uv = vin_conv_done && vin_under_limit;
   wire logic evt_ton    = |ton_max_expired;

   wire logic shut_ot     = evt_ot     && afr_pkg::afr_shuts(ot_react);
   wire logic shut_ut     = evt_ut     && afr_pkg::afr_shuts(ut_react);
   wire logic shut_vin_ov = evt_vin_ov && afr_pkg::afr_shuts(vin_ov_react);
   wire logic shut_vin_uv = evt_vin_uv && afr_pkg::afr_shuts(vin_uv_react);
   wire logic adc_shut    = shut_ot || shut_ut || shut_vin_ov || shut_vin_uv;
   wire logic ton_shuts   = afr_pkg::afr_shuts(ton_react);

   // adc_retry takes the retry policy of the first shutting fault in this order;
   // with several at once the channel gets a zero retry field instead and latches
   wire logic [2:0] adc_retry =
      shut_ot     ? afr_pkg::afr_retry(ot_react)     :
      shut_ut     ? afr_pkg::afr_retry(ut_react)     :
      shut_vin_ov ? afr_pkg::afr_retry(vin_ov_react) :
                    afr_pkg::afr_retry(vin_uv_react);
   wire logic multi_adc = (32'(shut_ot) + 32'(shut_ut) + 32'(shut_vin_ov)
                           + 32'(shut_vin_uv)) > 32'd1;

   // ------------------------------------------------------------------
   // status flags
   // ------------------------------------------------------------------
   logic       st_temp_r;
   logic       st_vin_uv_r;
   logic       st_input_r;
   logic       st_vout_r;
   logic       st_high_r;
   logic       si_vin_ov_r;
   logic       si_vin_uv_r;
   logic       stt_ot_r;
   logic       stt_ut_r;
   logic [7:0] ton_flag_r;

   // set wins over a clear-faults landing in the same cycle
   function automatic logic flag_nxt(input logic cur, input logic set, input logic clr);
      return set || (cur && !clr);
   endfunction

   wire logic any_input = evt_vin_ov || evt_vin_uv;

   // one short block per flag keeps each set and clear path easy to follow
   always_ff @(posedge mclk) begin
      if (srst) begin
         st_temp_r <= 1'b0;
      end else begin
         st_temp_r <= flag_nxt(st_temp_r, evt_ot || evt_ut, clr_flt);
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         st_vin_uv_r <= 1'b0;
      end else begin
         st_vin_uv_r <= flag_nxt(st_vin_uv_r, evt_vin_uv, clr_flt);
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         st_input_r <= 1'b0;
      end else begin
         st_input_r <= flag_nxt(st_input_r, any_input, clr_flt);
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         si_vin_ov_r <= 1'b0;
      end else begin
         si_vin_ov_r <= flag_nxt(si_vin_ov_r, evt_vin_ov, clr_flt);
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         si_vin_uv_r <= 1'b0;
      end else begin
         si_vin_uv_r <= flag_nxt(si_vin_uv_r, evt_vin_uv, clr_flt);
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         stt_ot_r <= 1'b0;
      end else begin
         stt_ot_r <= flag_nxt(stt_ot_r, evt_ot, clr_flt);
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         stt_ut_r <= 1'b0;
      end else begin
         stt_ut_r <= flag_nxt(stt_ut_r, evt_ut, clr_flt);
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         st_vout_r <= 1'b0;
      end else begin
         st_vout_r <= flag_nxt(st_vout_r, evt_ton, clr_flt);
      end
   end

   // vin over voltage has no own summary bit, so it shows in high byte
   always_ff @(posedge mclk) begin
      if (srst) begin
         st_high_r <= 1'b0;
      end else begin
         st_high_r <= flag_nxt(st_high_r, evt_ton || evt_vin_ov, clr_flt);
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         ton_flag_r <= 8'h00;
      end else begin
         ton_flag_r <= ton_max_expired | (clr_flt ? 8'h00 : ton_flag_r);
      end
   end

   // ------------------------------------------------------------------
   // host alert
   // ------------------------------------------------------------------
   wire logic alert_set = evt_ot || evt_ut || any_input || evt_ton;
   // kept inverted so the pin comes straight from a flop
   logic alert_n_r;

   always_ff @(posedge mclk) begin
      if (srst) begin
         alert_n_r <= 1'b1;
      end else begin
         alert_n_r <= !flag_nxt(!alert_n_r, alert_set, clr_flt);
      end
   end

   // ------------------------------------------------------------------
   // register reads
   // ------------------------------------------------------------------
   logic [7:0] sb_val, swh_val, si_val, stt_val, rd_nxt;

   always_comb begin
      sb_val  = 8'h00;
      swh_val = 8'h00;
      si_val  = 8'h00;
      stt_val = 8'h00;
      sb_val[afr_pkg::SB_HIGH_BYTE] = st_high_r;
      sb_val[afr_pkg::SB_TEMP]      = st_temp_r;
      sb_val[afr_pkg::SB_VIN_UV]    = st_vin_uv_r;
      swh_val[afr_pkg::SW_INPUT]    = st_input_r;
      swh_val[afr_pkg::SW_VOUT]     = st_vout_r;
      si_val[afr_pkg::SI_VIN_OV]    = si_vin_ov_r;
      si_val[afr_pkg::SI_VIN_UV]    = si_vin_uv_r;
      stt_val[afr_pkg::ST_OT]       = stt_ot_r;
      stt_val[afr_pkg::ST_UT]       = stt_ut_r;
      unique case (cmd_code)
         afr_pkg::CMD_STATUS_BYTE:    rd_nxt = sb_val;
         afr_pkg::CMD_STATUS_WORD_HI: rd_nxt = swh_val;
         afr_pkg::CMD_STATUS_INPUT:   rd_nxt = si_val;
         afr_pkg::CMD_STATUS_TEMP:    rd_nxt = stt_val;
         afr_pkg::CMD_TON_FLAGS:      rd_nxt = ton_flag_r;
         afr_pkg::CMD_OT_REACT:       rd_nxt = ot_react;
         afr_pkg::CMD_UT_REACT:       rd_nxt = ut_react;
         afr_pkg::CMD_VIN_OV_REACT:   rd_nxt = vin_ov_react;
         afr_pkg::CMD_VIN_UV_REACT:   rd_nxt = vin_uv_react;
         afr_pkg::CMD_TON_REACT:      rd_nxt = ton_react;
         afr_pkg::CMD_RESTART_LIMIT:  rd_nxt = {5'h00, limit_r};
         default:                     rd_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         rd_data  <= 8'h00;
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= cmd_rd;
         if (cmd_rd) rd_data <= rd_nxt;
      end
   end

   // ------------------------------------------------------------------
   // channel controllers
   // ------------------------------------------------------------------
   logic [7:0] pin_prev_r;
   logic [7:0] en_w;
   logic [7:0] lat_w;

   always_ff @(posedge mclk) begin
      if (srst) begin
         // follow the pins through reset so no false toggle shows after it
         pin_prev_r <= channel_control_pin;
      end else begin
         pin_prev_r <= channel_control_pin;
      end
   end

   for (genvar i = 0; i < afr_pkg::NUM_CHAN; i++) begin : g_chan
      afr_chan_if cif ();
      wire logic ton_hit = ton_max_expired[i] && ton_shuts;
      wire logic pin_tgl = channel_control_pin[i] ^ pin_prev_r[i];

      // a start-up timeout shuts only its own channel; with an ADC fault as well it forces a zero retry field
      assign cif.fault_shut    = adc_shut || ton_hit;
      assign cif.retry_field   = (ton_hit && adc_shut) ? 3'h0 :
                                 ton_hit ? afr_pkg::afr_retry(ton_react) :
                                 (multi_adc ? 3'h0 : adc_retry);
      assign cif.seq_style     = shutdown_style[i];
      assign cif.toff_done     = toff_done[i];
      assign cif.on_cmd        = channel_control_pin[i] && operation_on[i];
      // clear-faults is deliberately not a release source
      assign cif.release_latch = pin_tgl || operation_wr[i] || on_off_config_wr[i];
      assign cif.bias_ok       = bias_ok;
      assign cif.retry_limit   = limit_r;
      assign en_w[i]           = cif.chan_en;
      assign lat_w[i]          = cif.latched;

      afr_chan_ctl u_chan (
         .mclk (mclk),
         .srst (srst),
         .cif  (cif.chan)
      );
   end

   assign chan_enable  = en_w;
   assign chan_latched = lat_w;
   assign host_alert_n = alert_n_r;
endmodule

// [verification/afr_host_model.sv]
/*
 * Host side model: drives the decoded command bus, one write or read at a time.
 * Assumes a single bench process calls wr and rd.
 */
`timescale 1ns/1ps
module afr_host_model (
   input  wire logic       mclk,
   input  wire logic       rd_valid,
   input  wire logic [7:0] rd_data,
   output logic            cmd_wr,
   output logic            cmd_rd,
   output logic      [7:0] cmd_code,
   output logic      [7:0] cmd_wdata
);
   initial begin
      cmd_wr = 1'b0;
      cmd_rd = 1'b0;
      cmd_code = 8'h00;
      cmd_wdata = 8'h00;
   end
   // idle bus shows inverted leftovers, so a stale code can never pass for a live one
   task automatic wr(input logic [7:0] code, input logic [7:0] data);
      @(negedge mclk);
      cmd_code = code;
      cmd_wdata = data;
      cmd_wr = 1'b1;
      @(negedge mclk);
      cmd_wr = 1'b0;
      cmd_code = ~code;
      cmd_wdata = ~data;
   endtask
   task automatic rd(input logic [7:0] code, output logic [7:0] data);
      @(negedge mclk);
      cmd_code = code;
      cmd_rd = 1'b1;
      @(negedge mclk);
      cmd_rd = 1'b0;
      cmd_code = ~code;
      // the answer stands for one cycle only, so it is taken here, mid-cycle
      data = (rd_valid === 1'b1) ? rd_data : 8'hxx;
   endtask
endmodule

// [verification/afr_fault_resp_assertions.sv]
/*
 * Port-level checks of the fault response block.
 * Assumes it is bound onto afr_fault_resp; ports match by name.
 */
`timescale 1ns/1ps
module afr_resp_chk (
   input wire logic       mclk,
   input wire logic       srst,
   input wire logic       cmd_wr,
   input wire logic       cmd_rd,
   input wire logic [7:0] cmd_code,
   input wire logic       temp_conv_done,
   input wire logic       temp_over_limit,
   input wire logic       temp_under_limit,
   input wire logic       vin_conv_done,
   input wire logic       vin_over_limit,
   input wire logic       vin_under_limit,
   input wire logic [7:0] ton_max_expired,
   input wire logic [7:0] toff_done,
   input wire logic       bias_ok,
   input wire logic [7:0] rd_data,
   input wire logic       rd_valid,
   input wire logic [7:0] chan_enable,
   input wire logic [7:0] chan_latched,
   input wire logic       host_alert_n
);
   default clocking @(posedge mclk);
   endclocking
   default disable iff (srst);
   logic adc_evt;
   logic evt0;
   logic clr_wr;
   logic react_rd;
   assign adc_evt = (temp_conv_done & (temp_over_limit | temp_under_limit))
                  | (vin_conv_done & (vin_over_limit | vin_under_limit));
   assign evt0 = adc_evt | ton_max_expired[0];
   assign clr_wr = cmd_wr & (cmd_code == afr_pkg::CMD_CLEAR_FAULTS);
   assign react_rd = cmd_rd & (cmd_code inside {afr_pkg::CMD_OT_REACT, afr_pkg::CMD_UT_REACT,
      afr_pkg::CMD_VIN_OV_REACT, afr_pkg::CMD_VIN_UV_REACT, afr_pkg::CMD_TON_REACT});
   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   read_answer_a: assert property (cmd_rd |=> rd_valid) else $error("read not answered");
   read_pulse_a: assert property (rd_valid |-> $past(cmd_rd)) else $error("stray read valid");
   delay_zero_a: assert property (react_rd |=> rd_data[2:0] == afr_pkg::DELAY_HARD)
      else $error("delay field not zero");
   adc_alert_a: assert property (adc_evt |=> !host_alert_n) else $error("no alert");
   ton_alert_a: assert property (|ton_max_expired |=> !host_alert_n)
      else $error("no timeout alert");
   alert_hold_a: assert property (!host_alert_n && !clr_wr |=> !host_alert_n)
      else $error("alert dropped");
   alert_clear_a: assert property (clr_wr && !adc_evt && !(|ton_max_expired)
      |=> host_alert_n) else $error("alert not released");
   latch_off_a: assert property (chan_latched[0] |-> !chan_enable[0])
      else $error("latched channel on");
   latch_cause_a: assert property ($rose(chan_latched[0]) |->
      $past(evt0) || $past(toff_done[0])) else $error("latch without cause");
   bias_off_a: assert property (!bias_ok |=> (chan_enable == 8'h00 && chan_latched == 8'h00))
      else $error("bias loss ignored");
   cover property ($rose(chan_latched[3]));
   cover property ($fell(host_alert_n));
   cover property (react_rd);
endmodule

bind afr_fault_resp afr_resp_chk u_chk (.*);

// [verification/tb.sv]
/*
 * Self-checking bench for the fault response block.
 * Assumes the host model drives the command bus; all else driven here at falling edges.
 */
`timescale 1ns/1ps
module tb;
   logic       mclk = 1'b0;
   logic       srst = 1'b1;
   logic [7:0] rd_data, chan_enable, chan_latched, cmd_code, cmd_wdata;
   logic       rd_valid, host_alert_n, cmd_wr, cmd_rd;
   logic       temp_conv_done = 1'b0, temp_over_limit = 1'b0, temp_under_limit = 1'b0;
   logic       vin_conv_done = 1'b0, vin_over_limit = 1'b0, vin_under_limit = 1'b0;
   logic       bias_ok = 1'b1;
   logic [7:0] ton_max_expired = 8'h00, channel_control_pin = 8'hFF, operation_on = 8'hFF;
   logic [7:0] operation_wr = 8'h00, on_off_config_wr = 8'h00, shutdown_style = 8'h00;
   logic [7:0] toff_done = 8'h00;
   int         n_errors = 0, tests_run = 0, cycles = 0;
   logic [7:0] codes [5] = '{afr_pkg::CMD_OT_REACT, afr_pkg::CMD_UT_REACT,
      afr_pkg::CMD_VIN_OV_REACT, afr_pkg::CMD_VIN_UV_REACT, afr_pkg::CMD_TON_REACT};

   afr_fault_resp DUT (.*);
   afr_host_model host (.*);

   initial begin
      forever #4 mclk = ~mclk;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic pulse8(ref logic [7:0] s, input logic [7:0] v);
      @(negedge mclk);
      s = v;
      @(negedge mclk);
      s = 8'h00;
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rdchk(input logic [7:0] code, input logic [7:0] exp);
      logic [7:0] d;
      host.rd(code, d);
      chk8(d, exp);
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // a hang counts as a mismatch and still reaches the report
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         wrap_up();
      end
   end

   initial begin
      tick(6);
      srst = 1'b0;
      tick(3);
      chk8({7'h00, host_alert_n}, 8'h01);
      rdchk(8'hEE, 8'h00);
      for (int i = 0; i < 5; i++) begin
         rdchk(codes[i], 8'h00);
         host.wr(codes[i], 8'hC7);
         rdchk(codes[i], 8'hC0);
         host.wr(codes[i], 8'h00);
      end
      temp_over_limit = 1'b1;
      tick(2);
      chk8({7'h00, host_alert_n}, 8'h01);
      temp_conv_done = 1'b1;
      tick(1);
      temp_conv_done = 1'b0;
      temp_over_limit = 1'b0;
      tick(2);
      chk8({7'h00, host_alert_n}, 8'h00);
      chk8(chan_enable, 8'hFF);
      rdchk(afr_pkg::CMD_STATUS_TEMP, 8'h80);
      rdchk(afr_pkg::CMD_STATUS_BYTE, 8'h04);
      host.wr(afr_pkg::CMD_CLEAR_FAULTS, 8'h00);
      rdchk(afr_pkg::CMD_STATUS_TEMP, 8'h00);
      host.wr(afr_pkg::CMD_VIN_UV_REACT, 8'h80);
      vin_under_limit = 1'b1;
      vin_conv_done = 1'b1;
      tick(1);
      vin_conv_done = 1'b0;
      vin_under_limit = 1'b0;
      tick(3);
      chk8(chan_enable, 8'h00);
      chk8(chan_latched, 8'hFF);
      rdchk(afr_pkg::CMD_STATUS_INPUT, 8'h10);
      rdchk(afr_pkg::CMD_STATUS_WORD_HI, 8'h20);
      host.wr(afr_pkg::CMD_CLEAR_FAULTS, 8'h00);
      tick(3);
      chk8({7'h00, host_alert_n}, 8'h01);
      chk8(chan_latched, 8'hFF);
      pulse8(operation_wr, 8'h01);
      channel_control_pin = 8'hFD;
      tick(1);
      channel_control_pin = 8'hFF;
      tick(4);
      chk8(chan_latched, 8'hFC);
      chk8(chan_enable, 8'h03);
      pulse8(on_off_config_wr, 8'hFC);
      tick(4);
      chk8(chan_enable, 8'hFF);
      host.wr(afr_pkg::CMD_RESTART_LIMIT, 8'h02);
      host.wr(afr_pkg::CMD_TON_REACT, 8'h48);
      for (int k = 0; k < 3; k++) begin
         pulse8(ton_max_expired, 8'h08);
         tick(4);
         chk8(chan_latched, (k == 2) ? 8'h08 : 8'h00);
         chk8(chan_enable, (k == 2) ? 8'hF7 : 8'hFF);
      end
      chk8({7'h00, host_alert_n}, 8'h00);
      rdchk(afr_pkg::CMD_TON_FLAGS, 8'h08);
      rdchk(afr_pkg::CMD_STATUS_BYTE, 8'h01);
      rdchk(afr_pkg::CMD_STATUS_WORD_HI, 8'h80);
      host.wr(afr_pkg::CMD_TON_REACT, 8'h40);
      shutdown_style = 8'h10;
      pulse8(ton_max_expired, 8'h10);
      tick(3);
      chk8(chan_enable, 8'hF7);
      pulse8(toff_done, 8'h10);
      tick(3);
      chk8(chan_enable, 8'hE7);
      chk8(chan_latched, 8'h18);
      bias_ok = 1'b0;
      tick(1);
      bias_ok = 1'b1;
      tick(4);
      chk8(chan_latched, 8'h00);
      chk8(chan_enable, 8'hFF);
      wrap_up();
   end
endmodule
